/* File: hw/acs_pkg.sv */
// Package for the converter sequencer: register map, fields, codes and timing
package acs_pkg;
  // Register word addresses on the bus
  localparam logic [7:0] ADDR_CTRL0     = 8'h00;
  localparam logic [7:0] ADDR_CTRL1     = 8'h04;
  localparam logic [7:0] ADDR_CTRL2     = 8'h08;
  localparam logic [7:0] ADDR_RES_HIGH  = 8'h0c;
  localparam logic [7:0] ADDR_RES_LOW   = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CTRL  = 8'h14;
  localparam logic [7:0] ADDR_SLEEP_ST  = 8'h18;
  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  // Implemented bit masks of the control registers
  localparam logic [7:0] CTRL0_MASK = 8'h7f;
  localparam logic [7:0] CTRL1_MASK = 8'hf3;
  localparam logic [7:0] CTRL2_MASK = 8'hf0;
  // Field positions
  localparam int ON_BIT   = 0;
  localparam int GO_BIT   = 1;
  localparam int CHS_LSB  = 2;
  localparam int JUST_BIT = 7;
  localparam int CKS_LSB  = 4;
  localparam int TRG_LSB  = 4;
  localparam int FLAG_BIT = 0;
  localparam int IEN_BIT  = 1;
  // Conversion clock select codes
  localparam logic [2:0] CKS_DIV2  = 3'h0;
  localparam logic [2:0] CKS_DIV4  = 3'h4;
  localparam logic [2:0] CKS_DIV8  = 3'h1;
  localparam logic [2:0] CKS_DIV16 = 3'h5;
  localparam logic [2:0] CKS_DIV32 = 3'h2;
  localparam logic [2:0] CKS_DIV64 = 3'h6;
  // Trigger select codes
  localparam logic [3:0] TRG_NONE = 4'h0;
  localparam logic [3:0] TRG_T0   = 4'h3;
  localparam logic [3:0] TRG_T1   = 4'h4;
  localparam logic [3:0] TRG_T2   = 4'h5;
  localparam logic [3:0] TRG_CMP1 = 4'h6;
  localparam logic [3:0] TRG_CMP2 = 4'h7;
  localparam logic [3:0] TRG_LC1  = 4'h8;
  localparam logic [3:0] TRG_LC2  = 4'h9;
  // Channel codes
  localparam logic [4:0] CHS_AIN_LAST = 5'h07;
  localparam logic [4:0] CHS_TEMP     = 5'h1d;
  localparam logic [4:0] CHS_DAC      = 5'h1e;
  localparam logic [4:0] CHS_FIXREF   = 5'h1f;
  // Reference codes
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_PIN    = 2'h2;
  // Timing: 11.5 bit periods are 23 half periods
  localparam int HALF_PERIODS = 23;
  localparam int RES_BITS     = 10;
  localparam int SYS_PER_INSN = 4;
  // Sequencer states
  typedef enum logic [3:0] {
    ACS_IDLE  = 4'b0001,
    ACS_DELAY = 4'b0010,
    ACS_CONV  = 4'b0100,
    ACS_DONE  = 4'b1000
  } acs_state_t;
endpackage

/* File: hw/acs_sequencer.sv */
// Conversion sequencer for a 10-bit successive-approximation converter with AHB-Lite registers
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Converter powers only while the on bit of control zero is set.
// - Writing one to go/done starts converting the selected channel.
// - Completion clears go/done, sets done flag, loads both result registers.
// - Clearing go/done aborts; partial result loads, unconverted bits copy last bit.
// - Reset returns every register to its reset value, ending any conversion.
// - Sleep conversion needs RC clock; RC start waits one extra instruction cycle.
// - Completion in Sleep with interrupt enabled wakes the device.
// - Completion in Sleep with interrupt disabled powers down, on bit kept.
// - Sleep with non-RC clock aborts conversion and powers down, on bit kept.
// - A selected trigger source sets go/done on each rising edge while the on bit is set.
// - Trigger select field in control two bits 7-4 picks the source.
// - Channel field bits 6-2 of control zero selects the analog channel.
// - Go/done reads one during conversion and zero when idle or done.
// - Justify bit picks right or left format, zero filling unused bits.
// - Clock field bits 6-4 of control one selects divider or RC clock.
// - Reference field bits 1-0 selects supply rail or external pin.
// - Left-justified high result holds the upper eight result bits.
// - Unimplemented control bits read as zero.
// - Done flag sets after every completed conversion; only software clears it.
// - One conversion lasts eleven and a half bit periods.
module acs_sequencer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Trigger sources, asynchronous
  input  wire logic        timer_zero_ovf,
  input  wire logic        timer_one_ovf,
  input  wire logic        timer_two_match,
  input  wire logic        comparator_one_output,
  input  wire logic        comparator_two_output,
  input  wire logic        logic_cell_one,
  input  wire logic        logic_cell_two,
  // Dedicated RC clock tick and sleep state, asynchronous
  input  wire logic        rc_tick,
  input  wire logic        sleep_req,
  // Comparator answer from the analog core, settled within a clock of sar_dac
  input  wire logic        sar_cmp,
  // Analog controls
  output logic             converter_power,
  output logic             sample_hold,
  output logic      [9:0]  sar_dac,
  output logic      [10:0] analog_channel_onehot,
  output logic             positive_ref_pin,
  output logic             conversion_irq,
  output logic             wake_req
);
  import acs_pkg::*;

  // Bus state and registers
  logic             ph_wr_r, ph_rd_r;
  logic [7:0]       ph_addr_r;
  logic [7:0]       ctrl0_r, ctrl1_r, ctrl2_r, res_high_r, res_low_r;
  logic             flag_r, irq_en_r;
  acs_state_t       state_r;
  logic [4:0]       half_cnt_r;
  logic [5:0]       div_cnt_r;
  logic [1:0]       insn_cnt_r;
  logic [9:0]       sar_r;
  logic [3:0]       bit_idx_r;
  logic [8:0]       trg_s1_r, trg_s2_r, trg_s3_r;
  logic             powered_down_r;

  // Synchroniser slots: 7 triggers, rc tick, sleep
  logic [8:0] async_in;
  assign async_in = {sleep_req, rc_tick, logic_cell_two, logic_cell_one, comparator_two_output,
                     comparator_one_output, timer_two_match, timer_one_ovf, timer_zero_ovf};
  // Two-stage synchroniser plus edge history stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trg_s1_r <= 9'h000;
      trg_s2_r <= 9'h000;
      trg_s3_r <= 9'h000;
    end else begin
      trg_s1_r <= async_in;
      trg_s2_r <= trg_s1_r;
      trg_s3_r <= trg_s2_r;
    end
  end
  // Trigger code to synchronised source
  function automatic logic trg_pick(input logic [3:0] code, input logic [8:0] v);
    unique case (code)
      TRG_T0:   return v[0];
      TRG_T1:   return v[1];
      TRG_T2:   return v[2];
      TRG_CMP1: return v[3];
      TRG_CMP2: return v[4];
      TRG_LC1:  return v[5];
      TRG_LC2:  return v[6];
      default:  return 1'b0;
    endcase
  endfunction
  // Divider terminal count per clock code, in clocks per half bit period minus one
  function automatic logic [5:0] div_half(input logic [2:0] code);
    unique case (code)
      CKS_DIV2:  return 6'h00;
      CKS_DIV4:  return 6'h01;
      CKS_DIV8:  return 6'h03;
      CKS_DIV16: return 6'h07;
      CKS_DIV32: return 6'h0f;
      CKS_DIV64: return 6'h1f;
      default:   return 6'h00;
    endcase
  endfunction
  logic       rc_sel, sleeping, trig_edge, rc_edge, half_tick, bus_go_set, bus_go_clr;
  logic       conv_last, abort;
  logic [2:0] cks;
  logic [7:0] wdata8;
  assign cks       = ctrl1_r[CKS_LSB +: 3];
  assign rc_sel    = (cks[1:0] == 2'b11);
  assign sleeping  = trg_s2_r[8];
  assign rc_edge   = trg_s2_r[7] & ~trg_s3_r[7];
  assign trig_edge = trg_pick(ctrl2_r[TRG_LSB +: 4], trg_s2_r) &
                     ~trg_pick(ctrl2_r[TRG_LSB +: 4], trg_s3_r);
  assign wdata8    = hwdata[7:0];
  assign bus_go_set = ph_wr_r && ph_addr_r == ADDR_CTRL0 && wdata8[GO_BIT];
  assign bus_go_clr = ph_wr_r && ph_addr_r == ADDR_CTRL0 && !wdata8[GO_BIT];
  // Half bit-period tick from divider or RC source
  assign half_tick = rc_sel ? rc_edge : (div_cnt_r == div_half(cks));
  assign conv_last = half_tick && half_cnt_r == 5'(HALF_PERIODS - 1);
  assign abort     = (state_r != ACS_IDLE) &&
                     (bus_go_clr || !ctrl0_r[ON_BIT] || (sleeping && !rc_sel));

  // AHB-Lite address phase capture; zero wait states, always OKAY
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ph_wr_r   <= 1'b0;
      ph_rd_r   <= 1'b0;
      ph_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ph_wr_r   <= hsel && hready && htrans[1] && hwrite;
      ph_rd_r   <= hsel && hready && htrans[1] && !hwrite;
      ph_addr_r <= haddr;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  // Read data, registered for the data phase
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr)
        ADDR_CTRL0:    hrdata <= {24'h0, ctrl0_r & CTRL0_MASK};
        ADDR_CTRL1:    hrdata <= {24'h0, ctrl1_r & CTRL1_MASK};
        ADDR_CTRL2:    hrdata <= {24'h0, ctrl2_r & CTRL2_MASK};
        ADDR_RES_HIGH: hrdata <= {24'h0, res_high_r};
        ADDR_RES_LOW:  hrdata <= {24'h0, res_low_r};
        ADDR_IRQ_CTRL: hrdata <= {30'h0, irq_en_r, flag_r};
        ADDR_SLEEP_ST: hrdata <= {30'h0, powered_down_r, sleeping};
        default:       hrdata <= 32'h0000_0000;
      endcase
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end

  // Control registers; hardware go/done handling
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl0_r <= CTRL0_RST;
      ctrl1_r <= CTRL1_RST;
      ctrl2_r <= CTRL2_RST;
    end else begin
      if (ph_wr_r && ph_addr_r == ADDR_CTRL0) begin
        ctrl0_r <= wdata8 & CTRL0_MASK;
      end
      if (ph_wr_r && ph_addr_r == ADDR_CTRL1) begin
        ctrl1_r <= wdata8 & CTRL1_MASK;
      end
      if (ph_wr_r && ph_addr_r == ADDR_CTRL2) begin
        ctrl2_r <= wdata8 & CTRL2_MASK;
      end
      // Hardware set wins over everything else
      if ((state_r == ACS_CONV && conv_last) || (abort && !bus_go_clr)) begin
        ctrl0_r[GO_BIT] <= 1'b0;
      end
      if (trig_edge && ctrl0_r[ON_BIT]) begin
        ctrl0_r[GO_BIT] <= 1'b1;
      end
    end
  end

  // Sequencer: idle, RC start delay, conversion, load
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= ACS_IDLE;
      half_cnt_r <= 5'h00;
      insn_cnt_r <= 2'h0;
    end else begin
      unique case (state_r)
        ACS_IDLE: begin
          half_cnt_r <= 5'h00;
          insn_cnt_r <= 2'h0;
          if (ctrl0_r[GO_BIT] && ctrl0_r[ON_BIT] && !(sleeping && !rc_sel)) begin
            state_r <= rc_sel ? ACS_DELAY : ACS_CONV;
          end
        end
        ACS_DELAY: begin
          insn_cnt_r <= insn_cnt_r + 2'h1;
          if (abort) begin
            state_r <= ACS_IDLE;
          end else if (insn_cnt_r == 2'(SYS_PER_INSN - 1)) begin
            state_r <= ACS_CONV;
          end
        end
        ACS_CONV: begin
          if (abort) begin
            state_r <= ACS_DONE;
          end else if (conv_last) begin
            state_r <= ACS_DONE;
          end else if (half_tick) begin
            half_cnt_r <= half_cnt_r + 5'h01;
          end
        end
        ACS_DONE: state_r <= ACS_IDLE;
      endcase
    end
  end

  // Half bit-period divider, restarted at conversion start
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_r <= 6'h00;
    end else if (state_r != ACS_CONV || half_tick) begin
      div_cnt_r <= 6'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 6'h01;
    end
  end

  // Successive approximation: one bit decided per bit period, MSB first
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sar_r     <= 10'h000;
      bit_idx_r <= 4'h0;
    end else if (state_r != ACS_CONV) begin
      sar_r     <= 10'h200;
      bit_idx_r <= 4'h0;
    end else if (half_tick && half_cnt_r[0] && half_cnt_r >= 5'h01 && bit_idx_r < 4'(RES_BITS)) begin
      sar_r[4'(RES_BITS - 1) - bit_idx_r] <= sar_cmp;
      if (bit_idx_r < 4'(RES_BITS - 1)) begin
        sar_r[4'(RES_BITS - 2) - bit_idx_r] <= 1'b1;
      end
      bit_idx_r <= bit_idx_r + 4'h1;
    end
  end

  // Fill undecided bits with the last decided bit on abort
  logic [9:0] final_res;
  always_comb begin
    final_res = sar_r;
    for (int i = 0; i < RES_BITS; i++) begin
      if (4'(RES_BITS - 1 - i) >= bit_idx_r && bit_idx_r != 4'h0) begin
        final_res[i] = sar_r[4'(RES_BITS) - bit_idx_r];
      end
    end
    if (bit_idx_r == 4'h0) begin
      final_res = 10'h000;
    end
  end
  // Result load on completion or abort, otherwise from bus writes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      res_high_r <= 8'h00;
      res_low_r  <= 8'h00;
    end else if (state_r == ACS_DONE) begin
      if (ctrl1_r[JUST_BIT]) begin
        res_high_r <= {6'h00, final_res[9:8]};
        res_low_r  <= final_res[7:0];
      end else begin
        res_high_r <= final_res[9:2];
        res_low_r  <= {final_res[1:0], 6'h00};
      end
    end else if (ph_wr_r && ph_addr_r == ADDR_RES_HIGH) begin
      res_high_r <= wdata8;
    end else if (ph_wr_r && ph_addr_r == ADDR_RES_LOW) begin
      res_low_r <= wdata8;
    end
  end

  // Done flag and interrupt enable; hardware set wins over software clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag_r   <= 1'b0;
      irq_en_r <= 1'b0;
    end else begin
      if (ph_wr_r && ph_addr_r == ADDR_IRQ_CTRL) begin
        irq_en_r <= wdata8[IEN_BIT];
        if (wdata8[FLAG_BIT]) begin
          flag_r <= 1'b0;
        end
      end
      if (state_r == ACS_CONV && conv_last) begin
        flag_r <= 1'b1;
      end
    end
  end

  // Sleep power-down and wake; cleared on leaving sleep or clearing the on bit
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      powered_down_r <= 1'b0;
      wake_req       <= 1'b0;
    end else begin
      wake_req <= sleeping && state_r == ACS_CONV && conv_last && irq_en_r;
      if (!sleeping || !ctrl0_r[ON_BIT]) begin
        powered_down_r <= 1'b0;
      end else if (state_r == ACS_CONV && conv_last && !irq_en_r) begin
        powered_down_r <= 1'b1;
      end else if (!rc_sel) begin
        powered_down_r <= 1'b1;
      end
    end
  end

  // Analog control outputs, all registered
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      converter_power       <= 1'b0;
      sample_hold           <= 1'b0;
      sar_dac               <= 10'h000;
      analog_channel_onehot <= 11'h000;
      positive_ref_pin      <= 1'b0;
      conversion_irq        <= 1'b0;
    end else begin
      converter_power  <= ctrl0_r[ON_BIT] && !powered_down_r;
      sample_hold      <= state_r == ACS_CONV;
      sar_dac          <= sar_r;
      positive_ref_pin <= ctrl1_r[1:0] == REF_PIN;
      conversion_irq   <= flag_r && irq_en_r;
      analog_channel_onehot <= 11'h000;
      if (ctrl0_r[CHS_LSB +: 5] <= CHS_AIN_LAST) begin
        analog_channel_onehot[ctrl0_r[CHS_LSB +: 3]] <= 1'b1;
      end else if (ctrl0_r[CHS_LSB +: 5] == CHS_TEMP) begin
        analog_channel_onehot[8] <= 1'b1;
      end else if (ctrl0_r[CHS_LSB +: 5] == CHS_DAC) begin
        analog_channel_onehot[9] <= 1'b1;
      end else if (ctrl0_r[CHS_LSB +: 5] == CHS_FIXREF) begin
        analog_channel_onehot[10] <= 1'b1;
      end
    end
  end
endmodule

/* File: bench/acs_sequencer_props.sv */
// Port-level checker for the converter sequencer
`timescale 1ns/1ps
module acs_sequencer_chk
  import acs_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // Sleep and analog side
  input wire logic        sleep_req,
  input wire logic        converter_power,
  input wire logic        sample_hold,
  input wire logic [10:0] analog_channel_onehot,
  input wire logic        positive_ref_pin,
  input wire logic        conversion_irq,
  input wire logic        wake_req
);
  logic       rd_r;
  logic       wr_r;
  logic [7:0] adr_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Marks the data phase of each taken transfer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
      adr_r <= 8'h00;
    end else begin
      rd_r  <= hsel && hready && htrans[1] && !hwrite;
      wr_r  <= hsel && hready && htrans[1] && hwrite;
      adr_r <= haddr;
    end
  end
  hold_powered_a: assert property (sample_hold |-> converter_power)
    else $error("sampling while converter unpowered");
  power_off_a: assert property (wr_r && adr_r == ADDR_CTRL0 && !hwdata[ON_BIT] |-> ##[1:3] !converter_power)
    else $error("converter still powered after on bit cleared");
  reset_quiet_a: assert property ($rose(arst_n) |-> !sample_hold && !converter_power && !conversion_irq)
    else $error("outputs active after reset");
  hold_min_a: assert property ($rose(sample_hold) |-> sample_hold[*8])
    else $error("conversion shorter than expected");
  wake_pulse_a: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  wake_cause_a: assert property (wake_req |-> $past(sleep_req, 4) ##[0:2] conversion_irq)
    else $error("wake request without sleep or interrupt");
  chan_onehot_a: assert property ($onehot0(analog_channel_onehot))
    else $error("more than one channel connected");
  ref_pin_a: assert property (wr_r && adr_r == ADDR_CTRL1 && hwdata[1:0] == REF_PIN |-> ##[1:3] positive_ref_pin)
    else $error("external reference not selected");
  unimpl_zero_a: assert property (rd_r |-> !(adr_r == ADDR_CTRL0 && hrdata[7]) && !(adr_r == ADDR_CTRL1
    && |hrdata[3:2]) && !(adr_r == ADDR_CTRL2 && |hrdata[3:0]))
    else $error("unimplemented control bit reads one");
  go_busy_a: assert property (rd_r && adr_r == ADDR_CTRL0 && $past(sample_hold) && sample_hold |-> hrdata[GO_BIT])
    else $error("go bit reads zero during conversion");
  // Main scenarios reached
  conv_c: cover property ($rose(sample_hold));
  wake_c: cover property (wake_req);
  ref_c: cover property (positive_ref_pin);
endmodule

bind acs_sequencer acs_sequencer_chk u_acs_sequencer_chk (
  .clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .sleep_req(sleep_req),
  .converter_power(converter_power), .sample_hold(sample_hold),
  .analog_channel_onehot(analog_channel_onehot), .positive_ref_pin(positive_ref_pin),
  .conversion_irq(conversion_irq), .wake_req(wake_req)
);

/* File: bench/acs_analog_model.sv */
// Behavioural analog core answering the trial code
`timescale 1ns/1ps
module acs_analog_model (
  // Clock and analog input level
  input  wire logic       clock,
  input  wire logic [9:0] vin,
  // Converter side
  input  wire logic       sample_hold,
  input  wire logic [9:0] sar_dac,
  output logic            sar_cmp
);
  logic wob_r = 1'b0;
  // Idle pattern so a stale answer is never taken for a real one
  always @(posedge clock) wob_r <= ~wob_r;
  // Input at or above the trial code answers high
  assign sar_cmp = sample_hold ? (vin >= sar_dac) : wob_r;
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module testbench;
  import acs_pkg::*;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [6:0]  trg = 7'h00;
  logic        rc_tick = 1'b0;
  logic        sleep_req = 1'b0;
  logic [9:0]  vin = 10'h000;
  logic [31:0] hrdata, q;
  logic        hreadyout, hresp, sar_cmp, converter_power, sample_hold, positive_ref_pin, conversion_irq, wake_req;
  logic [9:0]  sar_dac, r, ex, msk;
  logic [10:0] onehot;
  logic [2:0]  rc_div = 3'h0;
  logic        hold_q = 1'b0;
  logic        ok;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          hcnt = 0;
  logic [7:0]  rst_ad [4] = '{ADDR_CTRL0, ADDR_CTRL1, ADDR_CTRL2, 8'h1c};
  logic [4:0]  ch [6] = '{5'h00, CHS_AIN_LAST, 5'h08, 5'h1c, CHS_TEMP, CHS_DAC};
  logic [10:0] ch_ex [6] = '{11'h001, 11'h080, 11'h000, 11'h000, 11'h100, 11'h200};
  logic [2:0]  cks [6] = '{CKS_DIV2, CKS_DIV4, CKS_DIV8, CKS_DIV16, CKS_DIV32, CKS_DIV64};
  int          dv [6] = '{2, 4, 8, 16, 32, 64};
  logic [9:0]  vv [6] = '{10'h2a5, 10'h15a, 10'h3ff, 10'h001, 10'h200, 10'h1c3};
  acs_sequencer u_acs_sequencer (
    .clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_zero_ovf(trg[0]), .timer_one_ovf(trg[1]), .timer_two_match(trg[2]), .comparator_one_output(trg[3]),
    .comparator_two_output(trg[4]), .logic_cell_one(trg[5]), .logic_cell_two(trg[6]), .rc_tick(rc_tick),
    .sleep_req(sleep_req), .sar_cmp(sar_cmp), .converter_power(converter_power), .sample_hold(sample_hold),
    .sar_dac(sar_dac), .analog_channel_onehot(onehot), .positive_ref_pin(positive_ref_pin),
    .conversion_irq(conversion_irq), .wake_req(wake_req));
  acs_analog_model u_acs_analog_model (
    .clock(clock), .vin(vin), .sample_hold(sample_hold), .sar_dac(sar_dac), .sar_cmp(sar_cmp));
  // Clock generation
  initial begin
    forever #4 clock = ~clock;
  end
  // Cycle count, timeout, run length of sample_hold and a free RC clock
  always @(posedge clock) begin
    cyc <= cyc + 1;
    hold_q <= sample_hold;
    if (sample_hold === 1'b1) hcnt <= (hold_q === 1'b1) ? hcnt + 1 : 1;
    rc_div <= (rc_div == 3'h2) ? 3'h0 : rc_div + 3'h1;
    if (rc_div == 3'h2) rc_tick <= ~rc_tick;
    if (cyc == 90000) begin
      n_fail++;
      summarize();
    end
  end
  task summarize();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One AHB-Lite single transfer; read data lands in q
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task clks(input int n);
    repeat (n) @(posedge clock);
  endtask
  // On in one write, acquisition wait, then go in a later write
  task start(input logic [7:0] c0);
    wr(ADDR_CTRL0, {24'h0, c0 | 8'h01});
    clks(4);
    wr(ADDR_CTRL0, {24'h0, c0 | 8'h03});
  endtask
  task poll();
    int i;
    for (i = 0; i < 3000; i++) begin
      rd(ADDR_CTRL0);
      if (i == 0) chk("go_busy", q[GO_BIT], 1'b1);
      if (q[GO_BIT] === 1'b0) break;
    end
    chk("go_clear", q[GO_BIT], 1'b0);
    clks(3);
  endtask
  task t_regs();
    foreach (rst_ad[i]) begin
      rd(rst_ad[i]);
      chk("reset_value", q, 32'h0);
      chk("reset_okay", hresp, 1'b0);
    end
    wr(ADDR_CTRL1, 32'hff);
    rd(ADDR_CTRL1);
    chk("ctrl1_bits", q, 32'hf3);
    wr(ADDR_CTRL2, 32'hff);
    rd(ADDR_CTRL2);
    chk("ctrl2_bits", q, 32'hf0);
    wr(ADDR_CTRL0, 32'hfd);
    rd(ADDR_CTRL0);
    chk("ctrl0_bits", q, 32'h7d);
    chk("fixref_chan", onehot, 11'h400);
    chk("power_on", converter_power, 1'b1);
    foreach (ch[i]) begin
      wr(ADDR_CTRL0, {24'h0, 1'b0, ch[i], 2'b01});
      clks(3);
      chk("chan_decode", onehot, ch_ex[i]);
    end
    wr(ADDR_CTRL1, {30'h0, REF_PIN});
    clks(3);
    chk("ref_pin", positive_ref_pin, 1'b1);
    wr(ADDR_CTRL1, {30'h0, REF_SUPPLY});
    wr(ADDR_CTRL2, 32'h0);
    wr(ADDR_CTRL0, 32'h0);
    clks(3);
    chk("ref_supply", positive_ref_pin, 1'b0);
    chk("power_off", converter_power, 1'b0);
  endtask
  // Every divider, alternating justification
  task t_conv();
    foreach (cks[i]) begin
      vin = vv[i];
      wr(ADDR_CTRL1, {24'h0, ~i[0], cks[i], 4'h0});
      start(8'h00);
      poll();
      chk("conv_len", hcnt >= 23 * dv[i] / 2 && hcnt <= 23 * dv[i] / 2 + dv[i] + 4, 1'b1);
      rd(ADDR_RES_HIGH);
      chk("res_high", q, i[0] ? {24'h0, vin[9:2]} : {30'h0, vin[9:8]});
      rd(ADDR_RES_LOW);
      chk("res_low", q, i[0] ? {24'h0, vin[1:0], 6'h00} : {24'h0, vin[7:0]});
      rd(ADDR_IRQ_CTRL);
      chk("done_flag", q[FLAG_BIT], 1'b1);
      wr(ADDR_IRQ_CTRL, 32'h1);
      rd(ADDR_IRQ_CTRL);
      chk("flag_cleared", q[FLAG_BIT], 1'b0);
      rd(ADDR_RES_LOW);
      chk("res_kept", q, i[0] ? {24'h0, vin[1:0], 6'h00} : {24'h0, vin[7:0]});
    end
  endtask
  // None, reserved and every source code
  task t_trig();
    int c;
    wr(ADDR_CTRL1, 32'h80);
    wr(ADDR_CTRL0, 32'h01);
    for (c = 0; c < 10; c++) begin
      vin = 10'h0aa + 10'(c);
      wr(ADDR_CTRL2, {24'h0, 4'(c), 4'h0});
      clks(10);
      trg <= (c >= 3) ? 7'(1 << (c - 3)) : 7'h7f;
      clks(4);
      trg <= 7'h00;
      ok = 1'b0;
      repeat (30) begin
        if (!ok) @(posedge clock);
        if (sample_hold === 1'b1) ok = 1'b1;
      end
      chk("trig_start", ok, c >= 3);
      if (ok) poll();
      rd(ADDR_RES_LOW);
      if (ok) chk("trig_result", q, {24'h0, vin[7:0]});
      wr(ADDR_IRQ_CTRL, 32'h1);
    end
    wr(ADDR_CTRL2, 32'h0);
  endtask
  // Abort mid-way: converted prefix, then the last bit repeated
  task t_abort();
    int k;
    vin = 10'h2b6;
    wr(ADDR_CTRL1, {24'h0, 1'b1, CKS_DIV32, 4'h0});
    start(8'h00);
    clks(100);
    wr(ADDR_CTRL0, 32'h01);
    clks(5);
    rd(ADDR_RES_HIGH);
    r[9:8] = q[1:0];
    rd(ADDR_RES_LOW);
    r[7:0] = q[7:0];
    ok = 1'b0;
    for (k = 1; k <= 8; k++) begin
      msk = 10'h3ff << (10 - k);
      ex = (vin & msk) | (vin[10 - k] ? ~msk : 10'h000);
      if (r === ex) ok = 1'b1;
    end
    chk("abort_fill", ok, 1'b1);
    rd(ADDR_CTRL0);
    chk("abort_go", q, 32'h01);
  endtask
  task t_sleep();
    vin = 10'h13c;
    wr(ADDR_IRQ_CTRL, 32'h3);
    wr(ADDR_CTRL1, 32'hb0);
    start(8'h00);
    sleep_req <= 1'b1;
    ok = 1'b0;
    repeat (600) begin
      @(posedge clock);
      if (wake_req === 1'b1) ok = 1'b1;
    end
    chk("wake", ok, 1'b1);
    chk("irq_level", conversion_irq, 1'b1);
    sleep_req <= 1'b0;
    rd(ADDR_RES_LOW);
    chk("sleep_result", q, {24'h0, vin[7:0]});
    wr(ADDR_IRQ_CTRL, 32'h1);
    wr(ADDR_CTRL1, 32'hf0);
    start(8'h00);
    sleep_req <= 1'b1;
    clks(400);
    chk("sleep_off", converter_power, 1'b0);
    rd(ADDR_CTRL0);
    chk("sleep_on_kept", q, 32'h01);
    sleep_req <= 1'b0;
    wr(ADDR_CTRL0, 32'h0);
    wr(ADDR_CTRL1, {24'h0, 1'b1, CKS_DIV8, 4'h0});
    start(8'h00);
    clks(20);
    sleep_req <= 1'b1;
    clks(10);
    chk("sleep_abort", sample_hold, 1'b0);
    chk("sleep_abort_off", converter_power, 1'b0);
    rd(ADDR_CTRL0);
    chk("abort_on_kept", q, 32'h01);
    sleep_req <= 1'b0;
    wr(ADDR_CTRL0, 32'h0);
  endtask
  // Reset in mid-conversion
  task t_rst();
    wr(ADDR_CTRL1, {24'h0, 1'b1, CKS_DIV64, 4'h0});
    start(8'h08);
    clks(30);
    arst_n <= 1'b0;
    clks(2);
    arst_n <= 1'b1;
    clks(1);
    chk("rst_hold", sample_hold, 1'b0);
    chk("rst_power", converter_power, 1'b0);
    rd(ADDR_CTRL0);
    chk("rst_ctrl0", q, 32'h0);
    rd(ADDR_CTRL1);
    chk("rst_ctrl1", q, 32'h0);
  endtask
  // Main sequence
  initial begin
    clks(6);
    arst_n <= 1'b1;
    t_regs();
    t_conv();
    t_trig();
    t_abort();
    t_sleep();
    t_rst();
    summarize();
  end
endmodule
